// *** dv/ss2_ctrl_model.sv ***
// Behavioural motion controller driving the stop request, speeds and position.
`timescale 1ns/1ps
module ss2_ctrl_model (
	// Clock.
	input wire logic i_clk,
	// Bench controls.
	input wire logic i_req,
	input wire logic i_decel,
	input wire logic signed [15:0] i_step,
	input wire logic signed [15:0] i_cmd_set,
	input wire logic signed [15:0] i_fb_set,
	input wire logic signed [31:0] i_pos,
	// Monitor side.
	output logic o_safe_stop2_request,
	output logic signed [15:0] o_cmd_speed,
	output logic signed [15:0] o_fb_speed,
	output logic signed [31:0] o_position
);
	function automatic logic signed [15:0] ss2_toward_zero(input logic signed [15:0] v,
		input logic signed [15:0] s);
		if (v > s) begin
			return v - s;
		end else if (v < -s) begin
			return v + s;
		end
		return 16'sh0000;
	endfunction

	assign o_safe_stop2_request = i_req;
	assign o_position = i_pos;

	// With deceleration enabled the controller ramps both speeds to zero once it drops the request.
	always_ff @(posedge i_clk) begin
		if (i_decel && !i_req) begin
			o_cmd_speed <= ss2_toward_zero(o_cmd_speed, i_step);
			o_fb_speed <= ss2_toward_zero(o_fb_speed, i_step);
		end else begin
			o_cmd_speed <= i_cmd_set;
			o_fb_speed <= i_fb_set;
		end
	end
endmodule // ss2_ctrl_model

// *** dv/test_safe_stop2_standstill_monitor.sv ***
// Self-checking bench for the standstill monitor.
`timescale 1ns/1ps
`include "ss2_consts.svh"
module test_safe_stop2_standstill_monitor;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic req = 1'b1;
	logic dec = 1'b0;
	logic signed [15:0] step = 16'sh0001;
	logic signed [15:0] cmd_set = 16'sh0000;
	logic signed [15:0] fb_set = 16'sh0000;
	logic signed [31:0] pos = 32'sh0000_0000;
	logic [5:0] av_addr = 6'h00;
	logic av_read = 1'b0;
	logic av_write = 1'b0;
	logic [31:0] av_wdata = 32'h0000_0000;
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest;
	logic o_irq;
	logic o_standstill_status_output;
	logic o_sto_request;
	logic m_req;
	logic signed [15:0] m_cmd;
	logic signed [15:0] m_fb;
	logic signed [31:0] m_pos;
	logic [31:0] d;
	int err_total = 0;
	int num_checks = 0;

	always #10 i_clk = ~i_clk;

	ss2_ctrl_model i_ss2_ctrl_model (.i_clk(i_clk), .i_req(req), .i_decel(dec), .i_step(step),
		.i_cmd_set(cmd_set), .i_fb_set(fb_set), .i_pos(pos), .o_safe_stop2_request(m_req),
		.o_cmd_speed(m_cmd), .o_fb_speed(m_fb), .o_position(m_pos));

	ss2_monitor #(.TICK_CYCLES(4)) i_ss2_monitor (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_safe_stop2_request(m_req), .i_cmd_speed(m_cmd), .i_fb_speed(m_fb), .i_position(m_pos),
		.i_avs_address(av_addr), .i_avs_read(av_read), .i_avs_write(av_write),
		.i_avs_writedata(av_wdata), .o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest), .o_irq(o_irq),
		.o_standstill_status_output(o_standstill_status_output), .o_sto_request(o_sto_request));

	task results;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", name, exp, got);
			err_total++;
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// One Avalon access; the request is held until waitrequest is sampled low.
	task acc(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge i_clk);
		av_addr <= a;
		av_wdata <= wd;
		av_write <= wr;
		av_read <= !wr;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 50);
		rd = o_avs_readdata;
		av_write <= 1'b0;
		av_read <= 1'b0;
		if (o_avs_waitrequest !== 1'b0) begin
			$display("BAD waitrequest expected 0 seen %b", o_avs_waitrequest);
			err_total++;
			results();
		end
	endtask

	// Waits for standstill (0) or torque off (1) and checks the cycle count falls in lo..hi+1.
	task expect_rise(input int which, input int lo, input int hi);
		int n;
		logic s;
		n = 0;
		s = 1'b0;
		while (!s && n <= hi) begin
			@(posedge i_clk);
			n++;
			s = (which == 0) ? (o_standstill_status_output === 1'b1) : (o_sto_request === 1'b1);
		end
		num_checks++;
		if (!(s && n >= lo)) begin
			$display("BAD rise_%0d expected %0d..%0d seen %0d", which, lo, hi, n);
			err_total++;
			if (!s) begin
				results();
			end
		end
	endtask

	initial begin
		cyc(6);
		i_rstn <= 1'b1;
		cyc(4);
		acc(1'b0, `SS2_A_PAR_FIRST, 32'h0000_0000, d);
		chk("decel_time_reset", 32'h0000_03e8, d);
		acc(1'b0, `SS2_A_STATE, 32'h0000_0000, d);
		chk("state_idle", 32'h0000_0000, d);
		acc(1'b0, 6'h30, 32'h0000_0000, d);
		chk("unmapped", 32'h0000_0000, d);
		acc(1'b1, `SS2_A_PAR_FIRST, 32'h0000_00c8, d);
		acc(1'b0, `SS2_A_PAR_FIRST, 32'h0000_0000, d);
		chk("decel_time", 32'h0000_00c8, d);
		// Controller ramps from 300 to 0 at one count per cycle.
		dec <= 1'b1;
		cmd_set <= 16'sh012c;
		fb_set <= -16'sh012c;
		cyc(4);
		req <= 1'b0;
		cyc(8);
		acc(1'b0, `SS2_A_STATE, 32'h0000_0000, d);
		chk("state_decel", 32'h0000_0001, d);
		expect_rise(0, 265, 310);
		chk("sto_hold", 32'h0000_0000, 32'(o_sto_request));
		acc(1'b0, `SS2_A_STATE, 32'h0000_0000, d);
		chk("state_hold", 32'h0000_0002, d);
		acc(1'b0, `SS2_A_IRQ_STAT, 32'h0000_0000, d);
		chk("irq_status", 32'h0000_0003, d);
		chk("irq_masked", 32'h0000_0000, 32'(o_irq));
		acc(1'b1, `SS2_A_IRQ_MASK, 32'h0000_0001, d);
		cyc(2);
		chk("irq_on", 32'h0000_0001, 32'(o_irq));
		acc(1'b1, `SS2_A_IRQ_STAT, 32'h0000_0001, d);
		cyc(2);
		chk("irq_cleared", 32'h0000_0000, 32'(o_irq));
		acc(1'b0, `SS2_A_IRQ_STAT, 32'h0000_0000, d);
		chk("irq_status_w1c", 32'h0000_0002, d);
		acc(1'b1, `SS2_A_IRQ_MASK, 32'h0000_0000, d);
		// Commanded speed excess, interrupted once so the delay must restart.
		dec <= 1'b0;
		cmd_set <= 16'sh0050;
		fb_set <= 16'sh0000;
		cyc(20);
		cmd_set <= 16'sh0000;
		cyc(4);
		cmd_set <= 16'sh0050;
		expect_rise(1, 34, 60);
		chk("standstill_trip", 32'h0000_0000, 32'(o_standstill_status_output));
		acc(1'b0, `SS2_A_STATE, 32'h0000_0000, d);
		chk("state_trip", 32'h0000_0003, d);
		req <= 1'b1;
		cmd_set <= 16'sh0000;
		cyc(8);
		chk("sto_end", 32'h0000_0000, 32'(o_sto_request));
		acc(1'b0, `SS2_A_STATE, 32'h0000_0000, d);
		chk("state_end", 32'h0000_0000, d);
		// Measured speed excess, negative direction.
		req <= 1'b0;
		expect_rise(0, 36, 60);
		fb_set <= -16'sh0050;
		expect_rise(1, 36, 60);
		req <= 1'b1;
		fb_set <= 16'sh0000;
		cyc(8);
		// Travel exactly at the limit is allowed, one count beyond trips.
		req <= 1'b0;
		expect_rise(0, 36, 60);
		pos <= 32'sh0000_0064;
		cyc(80);
		chk("travel_limit", 32'h0000_0000, 32'(o_sto_request));
		pos <= -32'sh0000_0065;
		expect_rise(1, 36, 60);
		req <= 1'b1;
		pos <= 32'sh0000_0000;
		cyc(8);
		// Coarse travel unit: the same 101 counts stays inside 100 times 1024.
		acc(1'b1, `SS2_A_CTRL, 32'h0000_0002, d);
		req <= 1'b0;
		expect_rise(0, 36, 60);
		pos <= -32'sh0000_0065;
		cyc(80);
		chk("travel_unit", 32'h0000_0000, 32'(o_sto_request));
		chk("travel_unit_hold", 32'h0000_0001, 32'(o_standstill_status_output));
		req <= 1'b1;
		pos <= 32'sh0000_0000;
		cyc(8);
		// Supervision time of 20 ms runs out with the motor still turning.
		acc(1'b1, `SS2_A_PAR_FIRST, 32'h0000_0014, d);
		cmd_set <= 16'sh00c8;
		fb_set <= 16'sh00c8;
		cyc(4);
		req <= 1'b0;
		expect_rise(0, 78, 100);
		chk("no_env_trip", 32'h0000_0000, 32'(o_sto_request));
		req <= 1'b1;
		cyc(8);
		// Envelope enabled with a 5 ms start delay and constant speed.
		acc(1'b1, `SS2_A_PAR_FIRST, 32'h0000_03e8, d);
		acc(1'b1, 6'h20, 32'h0000_0005, d);
		acc(1'b1, `SS2_A_CTRL, 32'h0000_0001, d);
		req <= 1'b0;
		expect_rise(1, 54, 90);
		chk("env_no_hold", 32'h0000_0000, 32'(o_standstill_status_output));
		req <= 1'b1;
		cyc(8);
		// Longest shift holds the envelope flat at the captured 200 plus an offset of 8.
		acc(1'b1, 6'h18, 32'h0000_000f, d);
		acc(1'b1, 6'h1c, 32'h0000_0008, d);
		req <= 1'b0;
		cyc(8);
		fb_set <= 16'sh00d0;
		cyc(60);
		chk("env_offset", 32'h0000_0000, 32'(o_sto_request));
		fb_set <= 16'sh00d1;
		expect_rise(1, 36, 60);
		req <= 1'b1;
		cyc(8);
		results();
	end
endmodule // test_safe_stop2_standstill_monitor

// *** src/ss2_cfg_if.sv ***
// Settings from the register file to the monitor core, and events back.
`timescale 1ns/1ps
interface ss2_cfg_if;
	logic env_en;
	logic unit_sel;
	logic [15:0] par [0:7];
	logic [2:0] ev;
	logic [1:0] state_code;
	modport regs (output env_en, unit_sel, par, input ev, state_code);
	modport core (input env_en, unit_sel, par, output ev, state_code);
endinterface

// *** src/ss2_consts.svh ***
// Offsets, field positions, reset values and timing figures of the standstill monitor.
`ifndef SS2_CONSTS_SVH
`define SS2_CONSTS_SVH
`define SS2_CLK_NS 20
`define SS2_TICK_NS 1000000
`define SS2_A_CTRL 6'h00
`define SS2_A_PAR_FIRST 6'h04
`define SS2_A_PAR_LAST 6'h20
`define SS2_A_STATE 6'h24
`define SS2_A_IRQ_STAT 6'h28
`define SS2_A_IRQ_MASK 6'h2c
`define SS2_P_DECEL_TIME 3'h0
`define SS2_P_STOP_SPEED 3'h1
`define SS2_P_TRAVEL 3'h2
`define SS2_P_SPD_DELAY 3'h3
`define SS2_P_POS_DELAY 3'h4
`define SS2_P_ENV_TC 3'h5
`define SS2_P_ENV_OFFSET 3'h6
`define SS2_P_ENV_DELAY 3'h7
`define SS2_CTRL_ENV_BIT 0
`define SS2_CTRL_UNIT_BIT 1
`define SS2_UNIT_SHIFT 10
`define SS2_RST_CTRL 2'h0
`define SS2_RST_PAR 16'h0000
`define SS2_RST_DECEL_TIME 16'h03e8
`define SS2_RST_STOP_SPEED 16'h0032
`define SS2_RST_TRAVEL 16'h0064
`define SS2_RST_SPD_DELAY 16'h000a
`define SS2_RST_POS_DELAY 16'h000a
`define SS2_RST_ENV_TC 16'h0004
`define SS2_EV_START 0
`define SS2_EV_HOLD 1
`define SS2_EV_TRIP 2
`endif

// *** src/ss2_monitor.sv ***
// Safe stop 2 deceleration supervision and standstill monitor, top level.
//
// Overview of operation
// RULE1: Request going inactive starts the sequence with deceleration supervision.
// RULE2: Request returning active ends the whole sequence from any state.
// RULE3: Both speeds at or below stop speed for the delay start standstill monitoring.
// RULE4: Elapsed time beyond the supervision time also starts standstill monitoring.
// RULE5: Envelope checking runs only when its enable select bit is one.
// RULE6: Envelope checking starts after the envelope start delay has elapsed.
// RULE7: Speed above decaying envelope from captured speed plus offset trips torque off.
// RULE8: Commanded speed above stop speed for the delay trips torque off.
// RULE9: Measured speed above stop speed for the delay trips torque off.
// RULE10: Travel since standstill start beyond permitted distance for its delay trips.
// RULE11: Standstill status output is high exactly while standstill monitoring runs.
// RULE12: The controller decelerates the motor itself after dropping the request.
// RULE13: Persistence timers restart whenever their condition lapses.
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "ss2_consts.svh"
module ss2_monitor #(
	parameter int TICK_CYCLES = `SS2_TICK_NS / `SS2_CLK_NS
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rstn,
	// Controller and drive inputs.
	input wire logic i_safe_stop2_request,
	input wire logic signed [15:0] i_cmd_speed,
	input wire logic signed [15:0] i_fb_speed,
	input wire logic signed [31:0] i_position,
	// Avalon-MM slave.
	input wire logic [5:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Status and safety outputs.
	output logic o_irq,
	output logic o_standstill_status_output,
	output logic o_sto_request
);
	logic rst_meta_ff, rstn_ff;
	logic req_meta_ff, req_sync_ff;
	logic [15:0] tick_cnt_ff, nxt_tick_cnt;
	logic tick_ff, nxt_tick;
	ss2_pkg::ss2_state_t state_ff, nxt_state;
	logic [15:0] elapsed_ff, nxt_elapsed;
	logic [17:0] env_ff, nxt_env;
	logic signed [31:0] pos_start_ff, nxt_pos_start;
	logic sss_ff, nxt_sss;
	logic sto_ff, nxt_sto;
	logic [16:0] cmd_abs, fb_abs, stop_lim;
	logic signed [31:0] pos_diff;
	logic [31:0] travel_abs, travel_lim;
	logic env_active;
	logic [4:0] pcond, pclear, pdone;
	logic [15:0] pdelay [0:4];
	logic [2:0] ev;

	ss2_cfg_if cfg ();

	// The reset is released synchronously so no flop leaves reset a cycle apart.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta_ff <= 1'b0;
			rstn_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rstn_ff <= rst_meta_ff;
		end
	end

	// The request arrives from a pin; it starts high so a reset does not begin a stop.
	always_ff @(posedge i_clk or negedge rstn_ff) begin
		if (!rstn_ff) begin
			req_meta_ff <= 1'b1;
			req_sync_ff <= 1'b1;
		end else begin
			req_meta_ff <= i_safe_stop2_request;
			req_sync_ff <= req_meta_ff;
		end
	end

	// Millisecond tick for all supervision times.
	always_comb begin
		nxt_tick = 1'b0;
		nxt_tick_cnt = tick_cnt_ff + 16'h0001;
		if (tick_cnt_ff == 16'(TICK_CYCLES - 1)) begin
			nxt_tick_cnt = 16'h0000;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge rstn_ff) begin
		if (!rstn_ff) begin
			tick_cnt_ff <= 16'h0000;
			tick_ff <= 1'b0;
		end else begin
			tick_cnt_ff <= nxt_tick_cnt;
			tick_ff <= nxt_tick;
		end
	end

	// Magnitudes and limits.
	assign cmd_abs = i_cmd_speed[15] ? 17'(-i_cmd_speed) : {1'b0, i_cmd_speed};
	assign fb_abs = i_fb_speed[15] ? 17'(-i_fb_speed) : {1'b0, i_fb_speed};
	assign stop_lim = {1'b0, cfg.par[`SS2_P_STOP_SPEED]};
	assign pos_diff = i_position - pos_start_ff;
	assign travel_abs = pos_diff[31] ? 32'(-pos_diff) : 32'(pos_diff);
	// The unit select scales the permitted travel by 1024 counts.
	assign travel_lim = cfg.unit_sel ?
		({16'h0000, cfg.par[`SS2_P_TRAVEL]} << `SS2_UNIT_SHIFT) :
		{16'h0000, cfg.par[`SS2_P_TRAVEL]};
	assign env_active = cfg.env_en && elapsed_ff >= cfg.par[`SS2_P_ENV_DELAY]; // RULE5 RULE6

	// Persistence conditions: decel done, envelope, command, feedback, travel.
	always_comb begin
		pcond[0] = cmd_abs <= stop_lim && fb_abs <= stop_lim; // RULE3
		pcond[1] = env_active && {1'b0, fb_abs} > env_ff; // RULE7
		pcond[2] = cmd_abs > stop_lim; // RULE8
		pcond[3] = fb_abs > stop_lim; // RULE9
		pcond[4] = travel_abs > travel_lim; // RULE10
		pclear[0] = state_ff != ss2_pkg::ST_DECEL;
		pclear[1] = state_ff != ss2_pkg::ST_DECEL;
		pclear[2] = state_ff != ss2_pkg::ST_HOLD;
		pclear[3] = state_ff != ss2_pkg::ST_HOLD;
		pclear[4] = state_ff != ss2_pkg::ST_HOLD;
		pdelay[0] = cfg.par[`SS2_P_SPD_DELAY];
		pdelay[1] = cfg.par[`SS2_P_SPD_DELAY];
		pdelay[2] = cfg.par[`SS2_P_SPD_DELAY];
		pdelay[3] = cfg.par[`SS2_P_SPD_DELAY];
		pdelay[4] = cfg.par[`SS2_P_POS_DELAY];
	end

	for (genvar g = 0; g < 5; g++) begin : g_persist
		ss2_persist u_persist (
			.i_clk(i_clk),
			.i_rstn(rstn_ff),
			.i_tick(tick_ff),
			.i_delay(pdelay[g]),
			.i_clear(pclear[g]),
			.i_cond(pcond[g]),
			.o_done(pdone[g])
		);
	end

	// Sequence control.
	// A decay shift of zero empties the envelope on the first tick, so any motion trips.
	always_comb begin
		nxt_state = state_ff;
		nxt_elapsed = elapsed_ff;
		nxt_env = env_ff;
		nxt_pos_start = pos_start_ff;
		case (state_ff)
			ss2_pkg::ST_IDLE: begin
				if (!req_sync_ff) begin
					nxt_state = ss2_pkg::ST_DECEL; // RULE1
					nxt_elapsed = 16'h0000;
					nxt_env = 18'(fb_abs) + 18'(cfg.par[`SS2_P_ENV_OFFSET]); // RULE7
				end
			end
			ss2_pkg::ST_DECEL: begin
				if (req_sync_ff) begin
					nxt_state = ss2_pkg::ST_IDLE; // RULE2
				end else if (pdone[1]) begin
					nxt_state = ss2_pkg::ST_TRIP; // RULE7
				end else if (pdone[0] || elapsed_ff > cfg.par[`SS2_P_DECEL_TIME]) begin
					nxt_state = ss2_pkg::ST_HOLD; // RULE3 RULE4
					nxt_pos_start = i_position;
				end else if (tick_ff) begin
					if (elapsed_ff != 16'hffff) begin
						nxt_elapsed = elapsed_ff + 16'h0001;
					end
					nxt_env = env_ff - (env_ff >> cfg.par[`SS2_P_ENV_TC][3:0]); // RULE7
				end
			end
			ss2_pkg::ST_HOLD: begin
				if (req_sync_ff) begin
					nxt_state = ss2_pkg::ST_IDLE; // RULE2
				end else if (|pdone[4:2]) begin
					nxt_state = ss2_pkg::ST_TRIP; // RULE8 RULE9 RULE10
				end
			end
			ss2_pkg::ST_TRIP: begin
				if (req_sync_ff) begin
					nxt_state = ss2_pkg::ST_IDLE; // RULE2
				end
			end
			default: begin
				nxt_state = ss2_pkg::ST_IDLE;
			end
		endcase
		nxt_sss = nxt_state == ss2_pkg::ST_HOLD; // RULE11
		nxt_sto = nxt_state == ss2_pkg::ST_TRIP;
		ev[`SS2_EV_START] = state_ff == ss2_pkg::ST_IDLE && nxt_state == ss2_pkg::ST_DECEL;
		ev[`SS2_EV_HOLD] = state_ff != ss2_pkg::ST_HOLD && nxt_state == ss2_pkg::ST_HOLD;
		ev[`SS2_EV_TRIP] = state_ff != ss2_pkg::ST_TRIP && nxt_state == ss2_pkg::ST_TRIP;
	end

	always_ff @(posedge i_clk or negedge rstn_ff) begin
		if (!rstn_ff) begin
			state_ff <= ss2_pkg::ST_IDLE;
			elapsed_ff <= 16'h0000;
			env_ff <= 18'h0_0000;
			pos_start_ff <= 32'h0000_0000;
			sss_ff <= 1'b0;
			sto_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			elapsed_ff <= nxt_elapsed;
			env_ff <= nxt_env;
			pos_start_ff <= nxt_pos_start;
			sss_ff <= nxt_sss;
			sto_ff <= nxt_sto;
		end
	end

	assign cfg.ev = ev;
	assign cfg.state_code = state_ff;

	ss2_regs u_regs (
		.i_clk(i_clk),
		.i_rstn(rstn_ff),
		.i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read),
		.i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata),
		.o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.o_irq(o_irq),
		.cfg(cfg)
	);

	assign o_standstill_status_output = sss_ff;
	assign o_sto_request = sto_ff;

	// Properties run on the monitor clock and rest while the internal reset is low.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rstn_ff);

	sequence s_start;
		state_ff == ss2_pkg::ST_IDLE && !req_sync_ff;
	endsequence

	sequence s_hold_entry;
		state_ff == ss2_pkg::ST_DECEL && !req_sync_ff ##1 state_ff == ss2_pkg::ST_HOLD;
	endsequence

	seq_start_a: assert property (s_start |=> state_ff == ss2_pkg::ST_DECEL ##0 // RULE1
		elapsed_ff == 16'h0000)
		else $error("sequence did not start on request drop");
	seq_end_a: assert property (state_ff != ss2_pkg::ST_IDLE && req_sync_ff |=> // RULE2
		state_ff == ss2_pkg::ST_IDLE && !sss_ff && !sto_ff)
		else $error("sequence did not end on request return");
	decel_done_a: assert property (state_ff == ss2_pkg::ST_DECEL && !req_sync_ff && // RULE3
		pdone[0] && !pdone[1] |=> state_ff == ss2_pkg::ST_HOLD)
		else $error("stop speed reached but standstill not entered");
	decel_time_a: assert property (state_ff == ss2_pkg::ST_DECEL && !req_sync_ff && // RULE4
		elapsed_ff > cfg.par[`SS2_P_DECEL_TIME] |=> state_ff inside {ss2_pkg::ST_HOLD,
		ss2_pkg::ST_TRIP})
		else $error("deceleration time expired without standstill");
	env_enable_a: assert property (pcond[1] |-> cfg.env_en) // RULE5
		else $error("envelope checked while disabled");
	env_delay_a: assert property (pcond[1] |-> elapsed_ff >= cfg.par[`SS2_P_ENV_DELAY]) // RULE6
		else $error("envelope checked before its start delay");
	env_trip_a: assert property (state_ff == ss2_pkg::ST_DECEL && !req_sync_ff && // RULE7
		pdone[1] |=> sto_ff ##1 sto_ff || $past(req_sync_ff))
		else $error("envelope violation did not trip");
	cmd_trip_a: assert property (state_ff == ss2_pkg::ST_HOLD && !req_sync_ff && // RULE8
		pdone[2] |=> sto_ff && !sss_ff)
		else $error("command speed violation did not trip");
	fb_trip_a: assert property (state_ff == ss2_pkg::ST_HOLD && !req_sync_ff && // RULE9
		pdone[3] |=> sto_ff && !sss_ff)
		else $error("feedback speed violation did not trip");
	travel_trip_a: assert property (state_ff == ss2_pkg::ST_HOLD && !req_sync_ff && // RULE10
		pdone[4] |=> sto_ff && !sss_ff)
		else $error("travel violation did not trip");
	pos_capture_a: assert property (s_hold_entry |-> pos_start_ff == $past(i_position)) // RULE10
		else $error("travel origin not captured at standstill entry");
	sss_track_a: assert property (##1 sss_ff == $past(nxt_state == ss2_pkg::ST_HOLD) && // RULE11
		sss_ff == (state_ff == ss2_pkg::ST_HOLD))
		else $error("standstill output does not match monitoring");
	persist_clr_a: assert property (!pcond[2] ##1 !pcond[2] |-> !pdone[2]) // RULE13
		else $error("persistence timer survived a lapse");
	persist_fb_a: assert property (!pcond[3] ##1 !pcond[3] |-> !pdone[3]) // RULE13
		else $error("feedback timer survived a lapse");
	persist_trav_a: assert property (!pcond[4] ##1 !pcond[4] |-> !pdone[4]) // RULE13
		else $error("travel timer survived a lapse");
	hold_stay_a: assert property (state_ff == ss2_pkg::ST_HOLD && !req_sync_ff && // RULE11
		!pdone[2] && !pdone[3] && !pdone[4] |=> state_ff == ss2_pkg::ST_HOLD && sss_ff)
		else $error("standstill monitoring left without cause");
	trip_latch_a: assert property (state_ff == ss2_pkg::ST_TRIP && !req_sync_ff |=> // RULE2
		state_ff == ss2_pkg::ST_TRIP && sto_ff)
		else $error("torque off released while request low");
	sto_idle_a: assert property (state_ff == ss2_pkg::ST_IDLE |-> !sto_ff && !sss_ff) // RULE11
		else $error("outputs active while idle");
	elapsed_count_a: assert property (state_ff == ss2_pkg::ST_DECEL && !req_sync_ff && // RULE4
		tick_ff && !pdone[0] && !pdone[1] && elapsed_ff != 16'hffff &&
		elapsed_ff <= cfg.par[`SS2_P_DECEL_TIME] |=>
		elapsed_ff == $past(elapsed_ff) + 16'h0001)
		else $error("deceleration time not counted per tick");
endmodule // ss2_monitor

// *** src/ss2_persist.sv ***
// Persistence timer: reports a condition that has held for a number of ticks.
`timescale 1ns/1ps
module ss2_persist (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rstn,
	// Timing.
	input wire logic i_tick,
	input wire logic [15:0] i_delay,
	// Condition.
	input wire logic i_clear,
	input wire logic i_cond,
	output logic o_done
);
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic done_ff;
	logic nxt_done;

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_done = done_ff;
		if (i_clear || !i_cond) begin
			nxt_cnt = 16'h0000; // RULE13
			nxt_done = 1'b0;
		end else if (cnt_ff >= i_delay) begin
			nxt_done = 1'b1;
		end else if (i_tick) begin
			nxt_cnt = cnt_ff + 16'h0001;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_ff <= 16'h0000;
			done_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	assign o_done = done_ff;
endmodule // ss2_persist

// *** src/ss2_pkg.sv ***
// Types shared by the standstill monitor modules.
package ss2_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_DECEL, ST_HOLD, ST_TRIP} ss2_state_t;
endpackage

// *** src/ss2_regs.sv ***
// Avalon-MM register file with interrupt status and mask.
`timescale 1ns/1ps
`include "ss2_consts.svh"
module ss2_regs (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rstn,
	// Avalon-MM slave.
	input wire logic [5:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_irq,
	// Core side.
	ss2_cfg_if.regs cfg
);
	localparam logic [15:0] PAR_RST [0:7] = '{`SS2_RST_DECEL_TIME, `SS2_RST_STOP_SPEED,
		`SS2_RST_TRAVEL, `SS2_RST_SPD_DELAY, `SS2_RST_POS_DELAY, `SS2_RST_ENV_TC,
		`SS2_RST_PAR, `SS2_RST_PAR};
	logic [1:0] ctrl_ff, nxt_ctrl;
	logic [15:0] par_ff [0:7];
	logic [15:0] nxt_par [0:7];
	logic [2:0] ist_ff, nxt_ist, imask_ff, nxt_imask;
	logic wait_ff, nxt_wait, irq_ff, nxt_irq;
	logic [31:0] rdata_ff, nxt_rdata;
	logic req, ack;
	logic [2:0] idx;

	assign req = i_avs_read || i_avs_write;
	assign ack = req && !wait_ff;
	assign idx = 3'(i_avs_address[5:2] - 4'h1);

	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_par = par_ff;
		nxt_imask = imask_ff;
		nxt_wait = !(req && wait_ff);
		nxt_rdata = rdata_ff;
		nxt_ist = ist_ff;
		if (ack && i_avs_write) begin
			if (i_avs_address == `SS2_A_CTRL) begin
				nxt_ctrl = i_avs_writedata[1:0];
			end else if (i_avs_address >= `SS2_A_PAR_FIRST &&
				i_avs_address <= `SS2_A_PAR_LAST) begin
				nxt_par[idx] = i_avs_writedata[15:0];
			end else if (i_avs_address == `SS2_A_IRQ_STAT) begin
				nxt_ist = ist_ff & ~i_avs_writedata[2:0];
			end else if (i_avs_address == `SS2_A_IRQ_MASK) begin
				nxt_imask = i_avs_writedata[2:0];
			end
		end
		// New events win over a clear in the same cycle.
		nxt_ist = nxt_ist | cfg.ev;
		if (req && wait_ff) begin
			if (i_avs_address == `SS2_A_CTRL) begin
				nxt_rdata = {30'h0000_0000, ctrl_ff};
			end else if (i_avs_address >= `SS2_A_PAR_FIRST &&
				i_avs_address <= `SS2_A_PAR_LAST) begin
				nxt_rdata = {16'h0000, par_ff[idx]};
			end else if (i_avs_address == `SS2_A_STATE) begin
				nxt_rdata = {30'h0000_0000, cfg.state_code};
			end else if (i_avs_address == `SS2_A_IRQ_STAT) begin
				nxt_rdata = {29'h0000_0000, ist_ff};
			end else if (i_avs_address == `SS2_A_IRQ_MASK) begin
				nxt_rdata = {29'h0000_0000, imask_ff};
			end else begin
				nxt_rdata = 32'h0000_0000;
			end
		end
		nxt_irq = |(ist_ff & imask_ff);
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl_ff <= `SS2_RST_CTRL;
			par_ff <= PAR_RST;
			ist_ff <= 3'h0;
			imask_ff <= 3'h0;
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0000_0000;
			irq_ff <= 1'b0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			par_ff <= nxt_par;
			ist_ff <= nxt_ist;
			imask_ff <= nxt_imask;
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
			irq_ff <= nxt_irq;
		end
	end

	assign cfg.env_en = ctrl_ff[`SS2_CTRL_ENV_BIT];
	assign cfg.unit_sel = ctrl_ff[`SS2_CTRL_UNIT_BIT];
	assign cfg.par = par_ff;
	assign o_avs_readdata = rdata_ff;
	assign o_avs_waitrequest = wait_ff;
	assign o_irq = irq_ff;
endmodule // ss2_regs
